// File: rtl/ivr_pkg.sv
package ivr_pkg;

  // Register map of the APB slave.
  localparam logic [11:0] GEN_CTRL_OFS = 12'h000;
  localparam logic [7:0] GEN_CTRL_RESET = 8'h00;

  // Field positions inside the general interrupt control register.
  localparam int UNLOCK_BIT = 0;
  localparam int SELECT_BIT = 1;
  localparam int RSVD_LO_BIT = 2;
  localparam int RSVD_HI_BIT = 4;
  localparam int EXT_EN_LO_BIT = 5;
  localparam int EXT_EN_W = 3;

  // Program memory word addresses.
  localparam int VEC_AW = 13;
  localparam logic [12:0] APP_RESET_BASE = 13'h0000;
  localparam logic [12:0] VEC_OFS = 13'h0002;
  localparam logic [12:0] BOOT_START_SZ0 = 13'h1C00;
  localparam logic [12:0] BOOT_START_SZ1 = 13'h1E00;
  localparam logic [12:0] BOOT_START_SZ2 = 13'h1F00;
  localparam logic [12:0] BOOT_START_SZ3 = 13'h1F80;

  // Length of the unlock window in system clock cycles.
  localparam int UNLOCK_WINDOW_CYCLES = 4;

  typedef enum logic [2:0] {
    IVR_IDLE = 3'b001,
    IVR_OPEN = 3'b010,
    IVR_HOLD = 3'b100
  } ivr_seq_t;

  typedef struct packed {
    ivr_seq_t seq;
    logic vector_base_select;
    logic [2:0] ext_en;
    logic irq_block;
    logic [12:0] vbase;
    logic [12:0] rst_addr;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ivr_state_t;

  localparam ivr_state_t IVR_ST_RESET = '{
    seq: IVR_IDLE,
    vector_base_select: 1'b0,
    ext_en: 3'h0,
    irq_block: 1'b0,
    vbase: 13'h0002,
    rst_addr: 13'h0000,
    prdata: 32'h0000_0000,
    pready: 1'b0,
    pslverr: 1'b0
  };

  typedef struct packed {
    logic [3:0] cnt;
  } ivr_timer_t;

endpackage

// File: rtl/ivr_unlock_timer.sv
`timescale 1ns/1ps
module ivr_unlock_timer #(
  parameter int WIN = ivr_pkg::UNLOCK_WINDOW_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic arm,
  input wire logic cancel,
  output logic open,
  output logic last
);

  ivr_pkg::ivr_timer_t st;
  ivr_pkg::ivr_timer_t nx;

  generate
    if ((WIN < 1) || (WIN > 15)) begin : g_bad_win
      $error("ivr_unlock_timer: WIN must lie between 1 and 15");
    end
  endgenerate

  // A fresh arm beats a cancel or the expiry in the same cycle.
  always_comb begin
    nx = st;
    if (arm) begin
      nx.cnt = 4'(WIN);
    end else if (cancel) begin
      nx.cnt = 4'h0;
    end else if (st.cnt != 4'h0) begin
      nx.cnt = st.cnt - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign open = (st.cnt != 4'h0);
  assign last = (st.cnt == 4'h1);

endmodule // ivr_unlock_timer

// File: rtl/ivr_vector_ctrl.sv
// Contract
// - Select bit clear: vector base is the start of program Flash.
// - Select bit set: vector base is the start of the boot section.
// - Boot section start, hence relocated base, follows the boot size fuses.
// - Select bit changes only by a zero-unlock write within four cycles of unlocking.
// - Unlock bit self-clears four cycles after setting or on the select write.
// - Interrupts blocked from unlock until the instruction after the select write ends.
// - Unlock without a select write blocks interrupts for four cycles only.
// - Automatic blocking never touches the core's global interrupt enable flag.
// - Boot vectors and app lock programmed: block while running in application.
// - App vectors and boot lock programmed: block while running in boot section.
// - Boot reset, 2K boot, select set: reset 1C00, vectors 1C02 up.
// - Reset fuse one gives reset 0000, zero gives boot start; vectors sit two above the base picked by the select bit.
`timescale 1ns/1ps
module ivr_vector_ctrl #(
  parameter int APB_AW = 12,
  parameter int UNLOCK_WIN = ivr_pkg::UNLOCK_WINDOW_CYCLES,
  parameter logic [12:0] BOOT_START_0 = ivr_pkg::BOOT_START_SZ0,
  parameter logic [12:0] BOOT_START_1 = ivr_pkg::BOOT_START_SZ1,
  parameter logic [12:0] BOOT_START_2 = ivr_pkg::BOOT_START_SZ2,
  parameter logic [12:0] BOOT_START_3 = ivr_pkg::BOOT_START_SZ3
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic boot_reset_fuse,
  input wire logic [1:0] boot_size_fuses,
  input wire logic app_side_boot_lock,
  input wire logic boot_side_boot_lock,
  input wire logic exec_in_boot,
  input wire logic instr_done,
  output logic [12:0] vector_base,
  output logic [12:0] reset_addr,
  output logic irq_block,
  output logic [2:0] ext_int_enable
);

  ivr_pkg::ivr_state_t st;
  ivr_pkg::ivr_state_t nx;
  logic reg_hit;
  logic access;
  logic wr_hit;
  logic arm;
  logic sel_wr;
  logic unlock_open;
  logic unlock_last;
  logic region_block;
  logic [7:0] read_val;

  generate
    if ((APB_AW < 3) || (APB_AW > 12)) begin : g_bad_aw
      $error("ivr_vector_ctrl: APB_AW must lie between 3 and 12");
    end
  endgenerate

  function automatic logic [12:0] boot_start(input logic [1:0] sz);
    case (sz)
      2'h0: boot_start = BOOT_START_0;
      2'h1: boot_start = BOOT_START_1;
      2'h2: boot_start = BOOT_START_2;
      default: boot_start = BOOT_START_3;
    endcase
  endfunction

  assign reg_hit = (paddr == ivr_pkg::GEN_CTRL_OFS[APB_AW-1:0]);
  assign access = psel & penable & st.pready;
  assign wr_hit = access & pwrite & reg_hit & pstrb[0];
  assign arm = wr_hit & pwdata[ivr_pkg::UNLOCK_BIT];
  // Writing the select bit with the unlock bit still high re-arms the window and leaves the select bit unchanged.
  assign sel_wr = wr_hit & ~pwdata[ivr_pkg::UNLOCK_BIT] & unlock_open;

  ivr_unlock_timer #(
    .WIN(UNLOCK_WIN)
  ) u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .arm(arm),
    .cancel(sel_wr),
    .open(unlock_open),
    .last(unlock_last)
  );

  always_comb begin
    read_val = 8'h00;
    read_val[ivr_pkg::UNLOCK_BIT] = unlock_open;
    read_val[ivr_pkg::SELECT_BIT] = st.vector_base_select;
    read_val[ivr_pkg::EXT_EN_LO_BIT +: ivr_pkg::EXT_EN_W] = st.ext_en;
    read_val[ivr_pkg::RSVD_HI_BIT:ivr_pkg::RSVD_LO_BIT] = 3'h0;
  end

  always_comb begin
    nx = st;
    nx.pready = 1'b1;
    region_block = 1'b0;
    // Read data and error are latched in the setup cycle so they are stable
    // through the zero-wait access phase.
    if (psel && !penable) begin
      nx.pslverr = ~reg_hit;
      nx.prdata = (reg_hit && !pwrite) ? {24'h00_0000, read_val} : 32'h0000_0000;
    end
    if (wr_hit) begin
      nx.ext_en = pwdata[ivr_pkg::EXT_EN_LO_BIT +: ivr_pkg::EXT_EN_W];
    end
    if (sel_wr) begin
      nx.vector_base_select = pwdata[ivr_pkg::SELECT_BIT];
    end
    case (st.seq)
      ivr_pkg::IVR_IDLE: begin
        if (arm) begin
          nx.seq = ivr_pkg::IVR_OPEN;
        end
      end
      ivr_pkg::IVR_OPEN: begin
        if (arm) begin
          nx.seq = ivr_pkg::IVR_OPEN;
        end else if (sel_wr) begin
          nx.seq = ivr_pkg::IVR_HOLD;
        end else if (unlock_last) begin
          nx.seq = ivr_pkg::IVR_IDLE;
        end
      end
      ivr_pkg::IVR_HOLD: begin
        // The select write's own completion is not counted; the next one is.
        if (arm) begin
          nx.seq = ivr_pkg::IVR_OPEN;
        end else if (instr_done) begin
          nx.seq = ivr_pkg::IVR_IDLE;
        end
      end
      default: begin
        nx.seq = ivr_pkg::IVR_IDLE;
      end
    endcase
    // Lock bits are active low: zero means programmed.
    region_block = (nx.vector_base_select && !app_side_boot_lock && !exec_in_boot)
        || (!nx.vector_base_select && !boot_side_boot_lock && exec_in_boot);
    // The block is a separate gate for the core; its enable flag stays as written.
    nx.irq_block = (nx.seq != ivr_pkg::IVR_IDLE) || region_block;
    nx.vbase = (nx.vector_base_select ? boot_start(boot_size_fuses) : ivr_pkg::APP_RESET_BASE)
        + ivr_pkg::VEC_OFS;
    nx.rst_addr = boot_reset_fuse ? ivr_pkg::APP_RESET_BASE
        : boot_start(boot_size_fuses);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= ivr_pkg::IVR_ST_RESET;
    end else begin
      st <= nx;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign vector_base = st.vbase;
  assign reset_addr = st.rst_addr;
  assign irq_block = st.irq_block;
  assign ext_int_enable = st.ext_en;

  AST_APP_VECTORS: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) && !st.vector_base_select |-> st.vbase == 13'h0002)
    else $error("Vector base not at start of Flash with select clear");

  AST_BOOT_VECTORS: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) && st.vector_base_select |-> st.vbase == boot_start($past(boot_size_fuses)) + 13'h0002)
    else $error("Vector base not at boot section start with select set");

  AST_BOOT_SIZE_TRACK: assert property (@(posedge clk) disable iff (!rst_b)
    st.vector_base_select && $stable(st.vector_base_select) && (boot_size_fuses != $past(boot_size_fuses))
    |=> st.vbase != $past(st.vbase))
    else $error("Relocated base ignored a boot size change");

  AST_SELECT_GUARDED: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) && (st.vector_base_select != $past(st.vector_base_select))
    |-> $past(wr_hit) && !$past(pwdata[0]) && $past(unlock_open))
    else $error("Select bit changed outside the unlock window");

  AST_UNLOCK_EXPIRES: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(unlock_open) ##0 (!wr_hit)[*4] |=> !unlock_open)
    else $error("Unlock bit still set four cycles after setting");

  AST_UNLOCK_HOLDS: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(unlock_open) ##0 (!wr_hit)[*3] |=> unlock_open)
    else $error("Unlock bit cleared before four cycles");

  AST_UNLOCK_CANCEL: assert property (@(posedge clk) disable iff (!rst_b)
    sel_wr |=> !unlock_open && (st.seq == ivr_pkg::IVR_HOLD))
    else $error("Select write did not clear the unlock bit");

  AST_BLOCK_ON_ARM: assert property (@(posedge clk) disable iff (!rst_b)
    arm |=> st.irq_block && unlock_open)
    else $error("Interrupts not blocked in the cycle the unlock bit is set");

  AST_BLOCK_UNTIL_NEXT: assert property (@(posedge clk) disable iff (!rst_b)
    sel_wr ##1 (!instr_done && !arm) |=> st.irq_block)
    else $error("Block released before the following instruction ended");

  AST_BLOCK_RELEASE: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(unlock_open) ##0 (!wr_hit)[*4] |=> st.irq_block == $past(region_block))
    else $error("Block did not end four cycles after an unused unlock");

  AST_APP_LOCK: assert property (@(posedge clk) disable iff (!rst_b)
    nx.vector_base_select && !app_side_boot_lock && !exec_in_boot |=> st.irq_block)
    else $error("Interrupts not suppressed in application with boot vectors");

  AST_BOOT_LOCK: assert property (@(posedge clk) disable iff (!rst_b)
    !nx.vector_base_select && !boot_side_boot_lock && exec_in_boot |=> st.irq_block)
    else $error("Interrupts not suppressed in boot section with app vectors");

  AST_BOOT_2K_MAP: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) && st.vector_base_select && !$past(boot_reset_fuse) && ($past(boot_size_fuses) == 2'h0)
    |-> (st.rst_addr == 13'h1C00) && (st.vbase == 13'h1C02))
    else $error("Boot map for the 2K boot section is wrong");

  AST_RESET_FUSE: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) |-> st.rst_addr == ($past(boot_reset_fuse) ? 13'h0000
        : boot_start($past(boot_size_fuses))))
    else $error("Reset address does not follow the boot reset fuse");

  AST_COUNT_FROM_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    arm ##1 (!wr_hit)[*3] |=> unlock_open && st.irq_block)
    else $error("Window did not start at the unlocking write");

  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    st.prdata[4:2] == 3'h0)
    else $error("Reserved control bits did not read as zero");

  AST_RESET_CLEAR: assert property (@(posedge clk)
    !rst_b |=> !st.vector_base_select && !unlock_open && (st.ext_en == 3'h0) && !st.irq_block)
    else $error("Fields not cleared by reset");

endmodule // ivr_vector_ctrl

// File: verification/ivr_vector_ctrl_tb.sv
`timescale 1ns/1ps
module ivr_vector_ctrl_tb;
  typedef struct packed {
    logic brst;
    logic [1:0] sz;
    logic sel;
    logic al;
    logic bl;
    logic eib;
    logic [12:0] vb;
    logic [12:0] ra;
    logic blk;
  } ivr_row_t;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic boot_reset_fuse = 1'h1;
  logic [1:0] boot_size_fuses = 2'h0;
  logic app_side_boot_lock = 1'h1;
  logic boot_side_boot_lock = 1'h1;
  logic exec_in_boot = 1'h0;
  logic instr_done = 1'h0;
  logic [12:0] vector_base;
  logic [12:0] reset_addr;
  logic irq_block;
  logic [2:0] ext_int_enable;
  int fail_count = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic err;
  logic cur_sel = 1'h0;
  // Lock inputs are active low: zero means the lock bit is programmed.
  ivr_row_t rows [8] = '{
    '{1'h1, 2'h0, 1'h0, 1'h1, 1'h1, 1'h0, 13'h0002, 13'h0000, 1'h0},
    '{1'h0, 2'h1, 1'h0, 1'h1, 1'h1, 1'h0, 13'h0002, ivr_pkg::BOOT_START_SZ1, 1'h0},
    '{1'h0, 2'h3, 1'h0, 1'h1, 1'h0, 1'h1, 13'h0002, ivr_pkg::BOOT_START_SZ3, 1'h1},
    '{1'h0, 2'h3, 1'h0, 1'h1, 1'h0, 1'h0, 13'h0002, ivr_pkg::BOOT_START_SZ3, 1'h0},
    '{1'h0, 2'h0, 1'h1, 1'h1, 1'h1, 1'h0, 13'h1C02, 13'h1C00, 1'h0},
    '{1'h1, 2'h2, 1'h1, 1'h0, 1'h1, 1'h0, ivr_pkg::BOOT_START_SZ2 + 13'h2, 13'h0, 1'h1},
    '{1'h1, 2'h2, 1'h1, 1'h0, 1'h1, 1'h1, ivr_pkg::BOOT_START_SZ2 + 13'h2, 13'h0, 1'h0},
    '{1'h0, 2'h1, 1'h1, 1'h1, 1'h0, 1'h1, ivr_pkg::BOOT_START_SZ1 + 13'h2,
      ivr_pkg::BOOT_START_SZ1, 1'h0}
  };

  ivr_vector_ctrl dut_u (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .boot_reset_fuse(boot_reset_fuse), .boot_size_fuses(boot_size_fuses),
    .app_side_boot_lock(app_side_boot_lock), .boot_side_boot_lock(boot_side_boot_lock),
    .exec_in_boot(exec_in_boot), .instr_done(instr_done), .vector_base(vector_base),
    .reset_addr(reset_addr), .irq_block(irq_block), .ext_int_enable(ext_int_enable)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Leaves psel up so that a following transfer can start in the next cycle.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'h1) begin
      fail_count++;
      give_verdict();
    end
  endtask

  task automatic idle();
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic relocate(input logic v, input int gap);
    apb(1'h1, 12'h000, 32'h1);
    if (gap > 0) begin
      idle();
      repeat (gap) @(posedge clk);
    end
    apb(1'h1, 12'h000, {30'h0, v, 1'h0});
    idle();
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("irq_block", 32'(irq_block), 32'h1);
    chk("vector_sel", 32'(vector_base != 13'h0002), 32'(v));
    @(posedge clk);
    instr_done <= 1'h1;
    @(posedge clk);
    instr_done <= 1'h0;
    @(negedge clk);
    chk("irq_block", 32'(irq_block), 32'h0);
    cur_sel = v;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("pready", 32'(pready), 32'h0);
    chk("vector_base", 32'(vector_base), 32'h2);
    @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    apb(1'h0, 12'h000, 32'h0);
    chk("reg", rd, 32'h0);
    apb(1'h1, 12'h000, 32'hFE);
    apb(1'h0, 12'h000, 32'h0);
    chk("reg", rd, 32'hE0);
    apb(1'h1, 12'h004, 32'h1);
    chk("pslverr", 32'(err), 32'h1);
    apb(1'h0, 12'h004, 32'h0);
    chk("unmapped_rd", rd, 32'h0);
    apb(1'h1, 12'h000, 32'h0);
    idle();
    @(negedge clk);
    chk("irq_block", 32'(irq_block), 32'h0);
    // A write without byte lane 0 must leave the register untouched.
    @(posedge clk);
    pstrb <= 4'hE;
    apb(1'h1, 12'h000, 32'hE1);
    pstrb <= 4'hF;
    apb(1'h0, 12'h000, 32'h0);
    idle();
    chk("strobe_reg", rd, 32'h0);
    @(negedge clk);
    chk("strobe_blk", 32'(irq_block), 32'h0);
    $display("test registers done");
    @(posedge clk);
    apb(1'h1, 12'h000, 32'h1);
    idle();
    for (int k = 0; k < 5; k++) begin
      if (k > 0) @(posedge clk);
      @(negedge clk);
      chk("irq_block", 32'(irq_block), 32'(k < 4));
    end
    @(posedge clk);
    apb(1'h1, 12'h000, 32'h2);
    apb(1'h0, 12'h000, 32'h0);
    idle();
    chk("reg", rd, 32'h0);
    @(negedge clk);
    $display("test expiry done");
    foreach (rows[i]) begin
      if (rows[i].sel !== cur_sel) begin
        @(posedge clk);
        relocate(rows[i].sel, 0);
      end
      @(posedge clk);
      boot_reset_fuse <= rows[i].brst;
      boot_size_fuses <= rows[i].sz;
      app_side_boot_lock <= rows[i].al;
      boot_side_boot_lock <= rows[i].bl;
      exec_in_boot <= rows[i].eib;
      repeat (2) @(posedge clk);
      apb(1'h0, 12'h000, 32'h0);
      idle();
      chk("reg", rd, {30'h0, rows[i].sel, 1'h0});
      @(negedge clk);
      chk("vector_base", 32'(vector_base), 32'(rows[i].vb));
      chk("reset_addr", 32'(reset_addr), 32'(rows[i].ra));
      chk("irq_block", 32'(irq_block), 32'(rows[i].blk));
    end
    $display("test rows done");
    @(posedge clk);
    exec_in_boot <= 1'h0;
    relocate(1'h0, 2);
    chk("vector_base", 32'(vector_base), 32'h2);
    $display("test window edge done");
    // Reset in the middle of an open unlock window must clear everything.
    @(posedge clk);
    apb(1'h1, 12'h000, 32'hE1);
    idle();
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    @(negedge clk);
    chk("rst_irq_block", 32'(irq_block), 32'h0);
    chk("rst_ext_en", 32'(ext_int_enable), 32'h0);
    @(posedge clk);
    apb(1'h0, 12'h000, 32'h0);
    idle();
    chk("rst_reg", rd, 32'h0);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule // ivr_vector_ctrl_tb
